/* File: spts_consts.svh */
// offsets, field positions, reset values of the priority/tag/stp block
// assumes inclusion by bare name from the design files
`ifndef SPTS_CONSTS_SVH
`define SPTS_CONSTS_SVH
`define SPTS_GRP_GLOBAL 4'h0
`define SPTS_GRP_DSCP   4'h1
`define SPTS_GRP_PORT0  4'h2
`define SPTS_GLB_TAGMAP 2'h0
`define SPTS_GLB_FOLD   2'h1
`define SPTS_GLB_STATUS 2'h2
`define SPTS_PRT_CTRL0  2'h0
`define SPTS_PRT_CTRL2  2'h1
`define SPTS_PRT_CTRL3  2'h2
`define SPTS_PRT_CTRL8  2'h3
`define SPTS_C0_TAG_REM 1
`define SPTS_C0_TAG_INS 2
`define SPTS_C0_PPRIO   3
`define SPTS_C0_TAG_EN  5
`define SPTS_C0_DSCP_EN 6
`define SPTS_C2_LRN_DIS 0
`define SPTS_C2_RX_EN   1
`define SPTS_C2_TX_EN   2
`define SPTS_C2_CEIL    7
`define SPTS_FOLD_POS   6
`define SPTS_RST_TAGMAP 16'hFA50
`define SPTS_RST_FOLD   2'h3
`define SPTS_RST_CTRL0  8'h00
`define SPTS_RST_CTRL2  8'h06
`define SPTS_RST_CTRL3  16'h0001
`define SPTS_RST_CTRL8  5'h1F
`define SPTS_TPID_HI    8'h81
`define SPTS_TPID_LO    8'h00
`define SPTS_TAG_POS    11'd12
`define SPTS_TAG_END    11'd15
`define SPTS_CRC_INIT   32'hFFFF_FFFF
`define SPTS_CRC_POLY   32'hEDB8_8320
`define SPTS_HOST_IDX   3'd4
`endif

/* File: spts_pkg.sv */
// types shared by the priority/tag/stp block
// assumes nothing beyond a SystemVerilog compiler
package spts_pkg;
  typedef enum logic [2:0] {EG_IDLE, EG_PASS, EG_INS, EG_FCS} spts_egr_e;
  typedef enum logic [1:0] {SRC_PORT, SRC_TAG, SRC_DSCP} spts_src_e;
endpackage : spts_pkg

/* File: spts_crc_if.sv */
// carrier between the egress editor and its fcs engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface spts_crc_if;
  logic        init;
  logic        en;
  logic [7:0]  data;
  logic [31:0] crc;
  modport user   (output init, output en, output data, input crc);
  modport engine (input init, input en, input data, output crc);
endinterface : spts_crc_if

/* File: spts_crc.sv */
// byte-wide ethernet fcs engine, reflected polynomial
// assumes init and en are driven on the same clock
`timescale 1ns/1ps
module spts_crc
  import spts_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset_n,
  spts_crc_if.engine  bus
);
`include "spts_consts.svh"

  logic [31:0] crc_reg;
  logic [31:0] seed;
  logic [31:0] crc_next;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `SPTS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // init restarts even when the first byte comes with it
  assign seed     = bus.init ? `SPTS_CRC_INIT : crc_reg;
  assign crc_next = bus.en ? crc_byte(seed, bus.data) : seed;
  assign bus.crc  = crc_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) crc_reg <= `SPTS_CRC_INIT;
    else          crc_reg <= crc_next;
  end
endmodule : spts_crc

/* File: spts_policy.sv */
// ingress priority classifier, egress tag editor and stp gating
// assumes an AHB-Lite master, frame streams without fcs on egress input
// Function
// - port priority gives each ingress frame its port level 0..3
// - port level three frames are high priority for a split queue
// - ports one to five hold port priority in control0 bits 4:3
// - tag priority reads the three-bit user priority of tagged frames
// - a programmable table maps priority 0..7 to levels 0..3
// - control0 bit 5 enables tag priority per port
// - control0 bit 2 enables insertion, a mask picks source ports
// - untagged frames get the ingress default tag, tagged never twice
// - a tag is a two-byte protocol id plus two-byte control field
// - control0 bit 1 strips tags from tagged frames only
// - fcs is recomputed after insertion or removal
// - control2 bit 7 clamps tag priority to the default tag priority
// - upper six tos bits index a 128-bit two-bit-per-point table
// - port five is the host port, stp applies to ports one to four
// - ports one to four hold transmit, receive and learn-disable bits
// - disabled ports pass no user frames and learn nothing
// - listening passes only host traffic and learns nothing
// - learning passes only host traffic but learns addresses
// - forwarding passes and receives user frames and learns
// - four queues: queue three highest, queue zero lowest
// - a global two-bit field folds tag and dscp levels into high or low queue
`timescale 1ns/1ps
module spts_policy
  import spts_pkg::*;
#(
  parameter int NUM_PORTS = 5
)(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  input  wire logic        CLS_VALID,
  input  wire logic [2:0]  CLS_PORT,
  input  wire logic        CLS_TAGGED,
  input  wire logic [2:0]  CLS_PCP,
  input  wire logic        CLS_IS_IP,
  input  wire logic [7:0]  CLS_TOS,
  input  wire logic        CLS_HOST_MATCH,
  output logic             CLS_DONE,
  output logic [1:0]       CLS_PRIO,
  output logic             CLS_HIGH,
  output logic [2:0]       CLS_PCP_OUT,
  output logic             CLS_ADMIT,
  output logic             CLS_LEARN,
  input  wire logic        EGR_VALID,
  input  wire logic        EGR_SOF,
  input  wire logic        EGR_LAST,
  input  wire logic [7:0]  EGR_DATA,
  input  wire logic [2:0]  EGR_SRC_PORT,
  input  wire logic [2:0]  EGR_PORT,
  input  wire logic        EGR_TAGGED,
  output logic             EGR_READY,
  output logic             TX_VALID,
  output logic [7:0]       TX_DATA,
  output logic             TX_LAST
);
`include "spts_consts.svh"

  if (NUM_PORTS != 5) begin : g_chk
    $error("spts_policy serves exactly five ports");
  end

  // configuration storage, index 0 is port one
  logic [7:0]  ctrl0_reg [NUM_PORTS];
  logic [7:0]  ctrl2_reg [NUM_PORTS];
  logic [15:0] deftag_reg [NUM_PORTS];
  logic [4:0]  insmask_reg [NUM_PORTS];
  logic [15:0] tagmap_reg;
  logic [1:0]  fold_reg;
  logic [31:0] dscp_reg [4];

  // bus slave
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic        addr_ok_reg;
  logic        hready_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_mux;
  logic [31:0] glb_rd;
  logic [31:0] port_rd;
  logic [1:0]  last_src_reg;
  logic        egr_busy;

  wire        ahb_go  = HSEL & HREADY & HTRANS[1];
  wire        addr_ok = (HADDR[31:8] == 24'h0) & (HSIZE == 3'b010);
  wire [3:0]  grp     = addr_reg[7:4];
  wire [1:0]  sel     = addr_reg[3:2];
  wire        we      = wr_pend_reg & addr_ok_reg;
  wire        is_port = (grp >= `SPTS_GRP_PORT0) && (grp < 4'(NUM_PORTS + 2));
  wire [2:0]  pidx    = 3'(grp - `SPTS_GRP_PORT0);
  wire        glb_we  = we && (grp == `SPTS_GRP_GLOBAL);
  wire        dscp_we = we && (grp == `SPTS_GRP_DSCP);

  // reads take one wait state so hrdata can leave a flop
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      addr_ok_reg <= 1'b0;
      hready_reg  <= 1'b1;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= ahb_go & HWRITE;
      rd_pend_reg <= ahb_go & ~HWRITE;
      if (ahb_go) begin
        addr_reg    <= HADDR[7:0];
        addr_ok_reg <= addr_ok;
      end
      hready_reg <= ~(ahb_go & ~HWRITE);
      hrdata_reg <= rd_pend_reg ? rd_mux : 32'h0000_0000;
    end
  end

  assign HREADYOUT = hready_reg;
  assign HRDATA    = hrdata_reg;

  always_ff @(posedge CLK) begin
    if (!RESET_N) HRESP <= 1'b0;
    else          HRESP <= 1'b0;
  end

  assign glb_rd = (sel == `SPTS_GLB_TAGMAP) ? {16'h0000, tagmap_reg} :
                  (sel == `SPTS_GLB_FOLD)   ? {24'h00_0000, fold_reg, 6'h00} :
                  (sel == `SPTS_GLB_STATUS) ? {28'h000_0000, egr_busy, 1'b0, last_src_reg} :
                  32'h0000_0000;
  assign port_rd = (sel == `SPTS_PRT_CTRL0) ? {24'h00_0000, ctrl0_reg[pidx]} :
                   (sel == `SPTS_PRT_CTRL2) ? {24'h00_0000, ctrl2_reg[pidx]} :
                   (sel == `SPTS_PRT_CTRL3) ? {16'h0000, deftag_reg[pidx]} :
                   {27'h000_0000, insmask_reg[pidx]};
  assign rd_mux = !addr_ok_reg                  ? 32'h0000_0000 :
                  (grp == `SPTS_GRP_GLOBAL)      ? glb_rd :
                  (grp == `SPTS_GRP_DSCP)        ? dscp_reg[sel] :
                  is_port                        ? port_rd :
                  32'h0000_0000;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      tagmap_reg <= `SPTS_RST_TAGMAP;
      fold_reg   <= `SPTS_RST_FOLD;
    end else if (glb_we && sel == `SPTS_GLB_TAGMAP) begin
      tagmap_reg <= HWDATA[15:0];
    end else if (glb_we && sel == `SPTS_GLB_FOLD) begin
      fold_reg <= HWDATA[`SPTS_FOLD_POS +: 2];
    end
  end

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    wire pw = we && is_port && (pidx == 3'(i));
    always_ff @(posedge CLK) begin
      if (!RESET_N) begin
        ctrl0_reg[i]   <= `SPTS_RST_CTRL0;
        ctrl2_reg[i]   <= `SPTS_RST_CTRL2;
        deftag_reg[i]  <= `SPTS_RST_CTRL3;
        insmask_reg[i] <= `SPTS_RST_CTRL8;
      end else if (pw) begin
        if (sel == `SPTS_PRT_CTRL0) ctrl0_reg[i] <= HWDATA[7:0];
        if (sel == `SPTS_PRT_CTRL2) ctrl2_reg[i] <= HWDATA[7:0];
        if (sel == `SPTS_PRT_CTRL3) deftag_reg[i] <= HWDATA[15:0];
        if (sel == `SPTS_PRT_CTRL8) insmask_reg[i] <= HWDATA[4:0];
      end
    end
  end

  for (genvar w = 0; w < 4; w++) begin : g_dscp
    always_ff @(posedge CLK) begin
      if (!RESET_N)                          dscp_reg[w] <= 32'h0000_0000;
      else if (dscp_we && sel == 2'(w))      dscp_reg[w] <= HWDATA;
    end
  end

  // ingress classification, one cycle from CLS_VALID to CLS_DONE
  wire        cls_ok   = (CLS_PORT >= 3'd1) && (CLS_PORT <= 3'd5);
  wire [2:0]  cidx     = cls_ok ? 3'(CLS_PORT - 3'd1) : `SPTS_HOST_IDX;
  wire [7:0]  c0       = ctrl0_reg[cidx];
  wire [7:0]  c2       = ctrl2_reg[cidx];
  wire [2:0]  def_pcp  = deftag_reg[cidx][15:13];
  wire        clamp    = c2[`SPTS_C2_CEIL] & CLS_TAGGED & (CLS_PCP > def_pcp);
  wire [2:0]  pcp_eff  = clamp ? def_pcp : CLS_PCP;
  wire [1:0]  tag_prio = tagmap_reg[{pcp_eff, 1'b0} +: 2];
  wire [5:0]  dscp     = CLS_TOS[7:2];
  wire [127:0] dscp_all = {dscp_reg[3], dscp_reg[2], dscp_reg[1], dscp_reg[0]};
  wire [1:0]  dscp_prio = dscp_all[{dscp, 1'b0} +: 2];
  wire [1:0]  port_prio = c0[`SPTS_C0_PPRIO +: 2];
  wire        use_tag  = c0[`SPTS_C0_TAG_EN] & CLS_TAGGED;
  wire        use_dscp = c0[`SPTS_C0_DSCP_EN] & CLS_IS_IP;
  wire [1:0]  prio     = use_tag ? tag_prio : use_dscp ? dscp_prio : port_prio;
  wire [1:0]  src      = use_tag ? SRC_TAG : use_dscp ? SRC_DSCP : SRC_PORT;
  // high-queue fold, port level three always high
  wire        high     = (src == SRC_PORT) ? (prio == 2'd3) : (prio >= fold_reg);
  wire        is_host  = (cidx == `SPTS_HOST_IDX);
  wire        admit    = is_host | c2[`SPTS_C2_RX_EN] | CLS_HOST_MATCH;
  wire        learn    = is_host | ~c2[`SPTS_C2_LRN_DIS];

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      CLS_DONE     <= 1'b0;
      CLS_PRIO     <= 2'd0;
      CLS_HIGH     <= 1'b0;
      CLS_PCP_OUT  <= 3'd0;
      CLS_ADMIT    <= 1'b0;
      CLS_LEARN    <= 1'b0;
      last_src_reg <= 2'd0;
    end else begin
      CLS_DONE <= CLS_VALID;
      if (CLS_VALID) begin
        // level doubles as four-queue index, three highest
        CLS_PRIO     <= prio;
        CLS_HIGH     <= high;
        CLS_PCP_OUT  <= pcp_eff;
        CLS_ADMIT    <= admit;
        CLS_LEARN    <= learn;
        last_src_reg <= src;
      end
    end
  end

  // egress editor
  spts_crc_if crc_bus ();

  spts_crc u_crc (
    .clk     (CLK),
    .reset_n (RESET_N),
    .bus     (crc_bus)
  );

  spts_egr_e   st_reg, st_next;
  logic [10:0] idx_reg, idx_next;
  logic [1:0]  cnt_reg, cnt_next;
  logic        ins_reg, ins_next;
  logic        rem_reg, rem_next;
  logic        drop_reg, drop_next;
  logic [15:0] tci_reg, tci_next;
  logic        rdy_reg, rdy_next;
  logic        txv_next;
  logic        txl_next;
  logic [7:0]  txd_next;

  wire       e_ok   = (EGR_PORT >= 3'd1) && (EGR_PORT <= 3'd5);
  wire       s_ok   = (EGR_SRC_PORT >= 3'd1) && (EGR_SRC_PORT <= 3'd5);
  wire [2:0] eidx   = e_ok ? 3'(EGR_PORT - 3'd1) : `SPTS_HOST_IDX;
  wire [2:0] sidx   = s_ok ? 3'(EGR_SRC_PORT - 3'd1) : `SPTS_HOST_IDX;
  // insert only on untagged frames from allowed sources
  wire       eg_ins = ctrl0_reg[eidx][`SPTS_C0_TAG_INS] & ~EGR_TAGGED &
                      insmask_reg[eidx][sidx];
  wire       eg_rem = ctrl0_reg[eidx][`SPTS_C0_TAG_REM] & EGR_TAGGED;
  // own port's transmit bit, host frames always pass
  wire       eg_drop = (eidx != `SPTS_HOST_IDX) & (sidx != `SPTS_HOST_IDX) &
                       ~ctrl2_reg[eidx][`SPTS_C2_TX_EN];
  wire       take    = EGR_VALID & rdy_reg;
  wire [10:0] idx_inc = idx_reg + 11'd1;
  wire       in_tag  = (idx_reg >= `SPTS_TAG_POS) && (idx_reg <= `SPTS_TAG_END);
  wire [7:0] tag_byte = (cnt_reg == 2'd0) ? `SPTS_TPID_HI :
                        (cnt_reg == 2'd1) ? `SPTS_TPID_LO :
                        (cnt_reg == 2'd2) ? tci_reg[15:8] : tci_reg[7:0];
  wire [7:0] fcs_byte = ~crc_bus.crc[{cnt_reg, 3'b000} +: 8];

  assign egr_busy = (st_reg != EG_IDLE);

  always_comb begin
    st_next   = st_reg;
    idx_next  = idx_reg;
    cnt_next  = cnt_reg;
    ins_next  = ins_reg;
    rem_next  = rem_reg;
    drop_next = drop_reg;
    tci_next  = tci_reg;
    rdy_next  = rdy_reg;
    txv_next  = 1'b0;
    txl_next  = 1'b0;
    txd_next  = TX_DATA;
    crc_bus.init = 1'b0;
    crc_bus.en   = 1'b0;
    crc_bus.data = 8'h00;
    case (st_reg)
      EG_IDLE: begin
        if (take && EGR_SOF) begin
          ins_next  = eg_ins;
          rem_next  = eg_rem & ~eg_ins;
          drop_next = eg_drop;
          tci_next  = deftag_reg[sidx];
          txv_next  = ~eg_drop;
          txd_next  = EGR_DATA;
          crc_bus.init = 1'b1;
          crc_bus.en   = 1'b1;
          crc_bus.data = EGR_DATA;
          idx_next  = 11'd1;
          cnt_next  = 2'd0;
          st_next   = EGR_LAST ? EG_FCS : EG_PASS;
          rdy_next  = ~EGR_LAST;
        end
      end
      EG_PASS: begin
        if (take) begin
          idx_next = idx_inc;
          if (!(rem_reg && in_tag)) begin
            txv_next     = ~drop_reg;
            txd_next     = EGR_DATA;
            crc_bus.en   = 1'b1;
            crc_bus.data = EGR_DATA;
          end
          if (EGR_LAST) begin
            st_next  = EG_FCS;
            rdy_next = 1'b0;
          end else if (ins_reg && idx_inc == `SPTS_TAG_POS) begin
            st_next  = EG_INS;
            rdy_next = 1'b0;
          end
        end
      end
      EG_INS: begin
        txv_next     = ~drop_reg;
        txd_next     = tag_byte;
        crc_bus.en   = 1'b1;
        crc_bus.data = tag_byte;
        cnt_next     = 2'(cnt_reg + 2'd1);
        if (cnt_reg == 2'd3) begin
          st_next  = EG_PASS;
          rdy_next = 1'b1;
        end
      end
      EG_FCS: begin
        // fcs over the edited byte stream
        txv_next = ~drop_reg;
        txd_next = fcs_byte;
        cnt_next = 2'(cnt_reg + 2'd1);
        if (cnt_reg == 2'd3) begin
          txl_next = ~drop_reg;
          st_next  = EG_IDLE;
          rdy_next = 1'b1;
        end
      end
      default: begin
        st_next  = EG_IDLE;
        rdy_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_reg   <= EG_IDLE;
      idx_reg  <= 11'd0;
      cnt_reg  <= 2'd0;
      ins_reg  <= 1'b0;
      rem_reg  <= 1'b0;
      drop_reg <= 1'b0;
      tci_reg  <= 16'h0000;
      rdy_reg  <= 1'b1;
    end else begin
      st_reg   <= st_next;
      idx_reg  <= idx_next;
      cnt_reg  <= cnt_next;
      ins_reg  <= ins_next;
      rem_reg  <= rem_next;
      drop_reg <= drop_next;
      tci_reg  <= tci_next;
      rdy_reg  <= rdy_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      TX_VALID <= 1'b0;
      TX_DATA  <= 8'h00;
      TX_LAST  <= 1'b0;
    end else begin
      TX_VALID <= txv_next;
      TX_DATA  <= txd_next;
      TX_LAST  <= txl_next;
    end
  end

  assign EGR_READY = rdy_reg;
endmodule : spts_policy

/* File: spts_policy_props.sv */
// concurrent checks on the policy block's bus, classifier and egress ports
// assumes a bind to spts_policy; one clock, synchronous active-low reset
`timescale 1ns/1ps
module spts_policy_props (
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic       HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic       HWRITE,
  input wire logic       HREADY,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  input wire logic       CLS_VALID,
  input wire logic       CLS_DONE,
  input wire logic [1:0] CLS_PRIO,
  input wire logic       CLS_HIGH,
  input wire logic       EGR_READY,
  input wire logic       TX_VALID,
  input wire logic       TX_LAST
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  property p_done; CLS_VALID |=> CLS_DONE; endproperty
  a_done: assert property (p_done) else $error("classify done missing");
  property p_pulse; !CLS_VALID |=> !CLS_DONE; endproperty
  a_pulse: assert property (p_pulse) else $error("classify done without request");
  property p_stable; !CLS_DONE |-> $stable(CLS_PRIO); endproperty
  a_stable: assert property (p_stable) else $error("priority moved between results");
  property p_high; CLS_DONE && CLS_PRIO == 2'h3 |-> CLS_HIGH; endproperty
  a_high: assert property (p_high) else $error("level three not high");
  property p_read; HSEL && HREADY && HTRANS[1] && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_read: assert property (p_read) else $error("read wait not one cycle");
  property p_write; HSEL && HREADY && HTRANS[1] && HWRITE |=> HREADYOUT; endproperty
  a_write: assert property (p_write) else $error("write stalled");
  property p_okay; !HRESP; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_fcs; TX_LAST |-> TX_VALID && $past(TX_VALID, 1) && $past(TX_VALID, 2)
    && $past(TX_VALID, 3); endproperty
  a_fcs: assert property (p_fcs) else $error("check sequence not four bytes");
  property p_gap; $fell(EGR_READY) |-> !EGR_READY [*4] ##1 EGR_READY; endproperty
  a_gap: assert property (p_gap) else $error("stall not four cycles");
endmodule : spts_policy_props

/* File: spts_link_model.sv */
// far-side link model: feeds egress frames, collects transmitted bytes
// assumes byte handshake on the egress ports, frames given without fcs
`timescale 1ns/1ps
module spts_link_model (
  input  wire logic       clk,
  output logic            egr_valid,
  output logic            egr_sof,
  output logic            egr_last,
  output logic [7:0]      egr_data,
  output logic [2:0]      egr_src_port,
  output logic [2:0]      egr_port,
  output logic            egr_tagged,
  input  wire logic       egr_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last
);
  logic [7:0] rxq[$];
  int         nlast = 0;
  initial begin
    egr_valid = 1'b0;
    egr_sof = 1'b0;
    egr_last = 1'b0;
    egr_data = 8'h00;
    egr_src_port = 3'h1;
    egr_port = 3'h1;
    egr_tagged = 1'b0;
  end
  function automatic logic [7:0] fb(input int i, input logic tg);
    if (tg && i == 12) return 8'h81;
    if (tg && i == 13) return 8'h00;
    return 8'(i * 7 + 3);
  endfunction : fb
  task automatic send(input logic [2:0] s, input logic [2:0] d, input logic tg, input int len,
                      input int gap);
    for (int i = 0; i < len; i++) begin
      egr_valid <= 1'b1;
      egr_sof <= (i == 0);
      egr_last <= (i == len - 1);
      egr_data <= fb(i, tg);
      egr_src_port <= s;
      egr_port <= d;
      egr_tagged <= tg;
      do @(posedge clk); while (egr_ready !== 1'b1);
      // idle data shows a changed value, not the last byte
      if (gap > 0 && i < len - 1) begin
        egr_valid <= 1'b0;
        egr_data <= ~egr_data;
        repeat (gap) @(posedge clk);
      end
    end
    egr_valid <= 1'b0;
    egr_sof <= 1'b0;
    egr_last <= 1'b0;
    egr_data <= ~egr_data;
  endtask : send
  always @(posedge clk) begin
    if (tx_valid === 1'b1) rxq.push_back(tx_data);
    if (tx_last === 1'b1) nlast <= nlast + 1;
  end
endmodule : spts_link_model

/* File: spts_policy_tb.sv */
// self-checking bench: bus tasks, classifier calls and egress frames
// assumes the link model on the egress side, single-word bus transfers
`timescale 1ns/1ps
module spts_policy_tb;
  import spts_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        cls_valid = 1'b0, cls_tagged = 1'b0, cls_is_ip = 1'b0, cls_host = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, cls_prio;
  logic [2:0]  hsize = 3'h2, cls_port = 3'h1, cls_pcp = 3'h0, cls_pcp_out, egr_src, egr_port;
  logic [7:0]  cls_tos = 8'h00, egr_data, tx_data;
  logic        hreadyout, hresp, cls_done, cls_high, cls_admit, cls_learn;
  logic        egr_valid, egr_sof, egr_last, egr_tagged, egr_ready, tx_valid, tx_last;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  logic [7:0]  exq[$];
  logic [31:0] ra[6] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_0024, 32'h0000_0028,
                         32'h0000_002C, 32'h0000_01FC};
  logic [31:0] rv[6] = '{32'h0000_FA50, 32'h0000_00C0, 32'h0000_0006, 32'h0000_0001,
                         32'h0000_001F, 32'h0000_0000};
  // {ctrl2, host match, admit, learn}
  logic [10:0] st[4] = '{{8'h06, 3'b011}, {8'h00, 3'b001}, {8'h01, 3'b110}, {8'h01, 3'b000}};

  spts_policy dut (
    .CLK(clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .CLS_VALID(cls_valid),
    .CLS_PORT(cls_port), .CLS_TAGGED(cls_tagged), .CLS_PCP(cls_pcp), .CLS_IS_IP(cls_is_ip),
    .CLS_TOS(cls_tos), .CLS_HOST_MATCH(cls_host), .CLS_DONE(cls_done), .CLS_PRIO(cls_prio),
    .CLS_HIGH(cls_high), .CLS_PCP_OUT(cls_pcp_out), .CLS_ADMIT(cls_admit),
    .CLS_LEARN(cls_learn), .EGR_VALID(egr_valid), .EGR_SOF(egr_sof), .EGR_LAST(egr_last),
    .EGR_DATA(egr_data), .EGR_SRC_PORT(egr_src), .EGR_PORT(egr_port),
    .EGR_TAGGED(egr_tagged), .EGR_READY(egr_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_LAST(tx_last)
  );
  spts_link_model link (
    .clk(clk), .egr_valid(egr_valid), .egr_sof(egr_sof), .egr_last(egr_last),
    .egr_data(egr_data), .egr_src_port(egr_src), .egr_port(egr_port),
    .egr_tagged(egr_tagged), .egr_ready(egr_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last)
  );

  initial forever #12.5 clk = ~clk;

  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic cls(input logic [2:0] p, input logic tg, input logic [2:0] pcp,
                     input logic ip, input logic [7:0] tos, input logic hm);
    cls_valid <= 1'b1;
    cls_port <= p;
    cls_tagged <= tg;
    cls_pcp <= pcp;
    cls_is_ip <= ip;
    cls_tos <= tos;
    cls_host <= hm;
    @(posedge clk);
    cls_valid <= 1'b0;
    @(posedge clk);
    chk("done", 32'h1, {31'h0, cls_done});
  endtask : cls

  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    return c;
  endfunction : crc8

  // expected bytes built from the frame, the edit and a fresh check sequence
  task automatic frame(input logic [2:0] s, input logic [2:0] d, input logic tg,
                       input logic ins, input logic rem, input logic drop, input int gap);
    int          n0;
    logic [31:0] c;
    n0 = link.nlast;
    link.rxq.delete();
    exq.delete();
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < 20; i++) begin
      if (ins && i == 12) exq = {exq, 8'h81, 8'h00, 8'h40, 8'h05};
      if (!(rem && i >= 12 && i < 16)) exq.push_back(link.fb(i, tg));
    end
    foreach (exq[i]) c = crc8(c, exq[i]);
    c = ~c;
    for (int k = 0; k < 4; k++) exq.push_back(c[8*k +: 8]);
    if (drop) exq.delete();
    link.send(s, d, tg, 20, gap);
    for (int k = 0; k < 40 && link.nlast == n0; k++) @(posedge clk);
    @(posedge clk);
    chk("tx_len", exq.size(), link.rxq.size());
    foreach (exq[i]) if (i < link.rxq.size()) chk("tx_byte", {24'h0, exq[i]}, {24'h0, link.rxq[i]});
  endtask : frame

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, ra[i], 32'h0, rd);
      chk("reset_value", rv[i], rd);
    end
    for (int l = 0; l < 4; l++) begin
      ahb(1'b1, 32'h0000_0030, 32'(l << 3), rd);
      ahb(1'b0, 32'h0000_0030, 32'h0, rd);
      chk("ctrl0", 32'(l << 3), rd);
      cls(3'h2, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0);
      chk("port_prio", 32'(l), {30'h0, cls_prio});
      chk("port_high", 32'(l == 3), {31'h0, cls_high});
    end
    ahb(1'b1, 32'h0000_0000, 32'h0000_1B1B, rd);
    ahb(1'b1, 32'h0000_0020, 32'h0000_0028, rd);
    for (int p = 0; p < 8; p++) begin
      cls(3'h1, 1'b1, 3'(p), 1'b0, 8'h00, 1'b0);
      chk("tag_prio", (32'h0000_1B1B >> (2 * p)) & 32'h3, {30'h0, cls_prio});
      chk("tag_high", 32'(p == 0 || p == 4), {31'h0, cls_high});
    end
    cls(3'h1, 1'b0, 3'h7, 1'b0, 8'h00, 1'b0);
    chk("untagged", 32'h1, {30'h0, cls_prio});
    ahb(1'b1, 32'h0000_0004, 32'h0000_0080, rd);
    cls(3'h1, 1'b1, 3'h1, 1'b0, 8'h00, 1'b0);
    chk("fold_high", 32'h1, {31'h0, cls_high});
    ahb(1'b1, 32'h0000_0028, 32'h0000_4005, rd);
    ahb(1'b1, 32'h0000_0024, 32'h0000_0086, rd);
    cls(3'h1, 1'b1, 3'h6, 1'b0, 8'h00, 1'b0);
    chk("ceil_pcp", 32'h2, {29'h0, cls_pcp_out});
    chk("ceil_prio", 32'h1, {30'h0, cls_prio});
    cls(3'h1, 1'b1, 3'h1, 1'b0, 8'h00, 1'b0);
    chk("below_ceil", 32'h1, {29'h0, cls_pcp_out});
    ahb(1'b1, 32'h0000_0040, 32'h0000_0042, rd);
    ahb(1'b1, 32'h0000_0014, 32'h0000_000C, rd);
    cls(3'h3, 1'b0, 3'h0, 1'b1, 8'h44, 1'b0);
    chk("cp_prio", 32'h3, {30'h0, cls_prio});
    ahb(1'b0, 32'h0000_0008, 32'h0, rd);
    chk("last_source", 32'h2, rd & 32'h3);
    cls(3'h3, 1'b0, 3'h0, 1'b1, 8'h40, 1'b0);
    chk("cp_zero", 32'h0, {30'h0, cls_prio});
    foreach (st[i]) begin
      ahb(1'b1, 32'h0000_0024, {24'h0, st[i][10:3]}, rd);
      cls(3'h1, 1'b0, 3'h0, 1'b0, 8'h00, st[i][2]);
      chk("admit", {31'h0, st[i][1]}, {31'h0, cls_admit});
      chk("learn", {31'h0, st[i][0]}, {31'h0, cls_learn});
    end
    cls(3'h2, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0);
    chk("other_port", 32'h3, {30'h0, cls_admit, cls_learn});
    ahb(1'b1, 32'h0000_0064, 32'h0000_0001, rd);
    cls(3'h5, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0);
    chk("host_port", 32'h3, {30'h0, cls_admit, cls_learn});
    ahb(1'b1, 32'h0000_0030, 32'h0000_0004, rd);
    frame(3'h1, 3'h2, 1'b0, 1'b1, 1'b0, 1'b0, 0);
    frame(3'h1, 3'h2, 1'b1, 1'b0, 1'b0, 1'b0, 0);
    frame(3'h1, 3'h3, 1'b1, 1'b0, 1'b1, 1'b0, 1);
    frame(3'h1, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    ahb(1'b1, 32'h0000_003C, 32'h0000_001E, rd);
    frame(3'h1, 3'h2, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    ahb(1'b1, 32'h0000_0054, 32'h0000_0001, rd);
    frame(3'h1, 3'h4, 1'b0, 1'b0, 1'b0, 1'b1, 0);
    frame(3'h5, 3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    stop_test();
  end
endmodule : spts_policy_tb

bind spts_policy spts_policy_props u_props (
  .CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CLS_VALID(CLS_VALID),
  .CLS_DONE(CLS_DONE), .CLS_PRIO(CLS_PRIO), .CLS_HIGH(CLS_HIGH), .EGR_READY(EGR_READY),
  .TX_VALID(TX_VALID), .TX_LAST(TX_LAST)
);
